// ==== rtl/psc_top.sv ====
// output shutdown control: fault pins force the six pwm pins, where pin_func_ok allows, to high impedance
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module psc_top (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    // axi4-lite write address
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [psc_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    // axi4-lite write data
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    // axi4-lite write response
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    output logic [1:0]                       s_axi_bresp,
    // axi4-lite read address
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    input  wire logic [psc_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    // axi4-lite read data
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    // fault pins, active low
    input  wire logic                        fault_in_a,
    input  wire logic                        fault_in_b,
    input  wire logic                        fault_in_c,
    // chip state, same clock domain
    input  wire logic                        standby_req,
    input  wire logic                        osc_halt,
    // pwm timer side: u_a, u_b, v_a, v_b, w_a, w_b in bits 0 to 5
    input  wire logic [5:0]                  timer_out,
    input  wire logic [5:0]                  timer_oe,
    input  wire logic [5:0]                  pin_func_ok,
    // pin side
    output logic [5:0]                       pin_out,
    output logic [5:0]                       pin_oe,
    // interrupt request, active high level
    output logic                             fault_irq
);
    typedef struct packed {
        logic [psc_pkg::ADDR_W-1:0] aw_addr;
        logic                       aw_have;
        logic [15:0]                w_data;
        logic [1:0]                 w_strb;
        logic                       w_have;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [31:0]                rdata;
        logic [2:0]                 flags;
        logic [2:0]                 seen;
        logic                       irq_en;
        logic [5:0]                 modes;
        logic [5:0]                 pin_out;
        logic [5:0]                 pin_oe;
        logic                       irq;
    } psc_top_state_t;

    psc_top_state_t r;
    psc_top_state_t n;
    logic [2:0]     det_req;
    logic [2:0]     tick;
    logic [2:0]     fault_n;
    logic           do_write;
    logic           wr_hit;
    logic           hiz;

    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    function automatic logic csr_hit(input logic [psc_pkg::ADDR_W-1:0] addr);
        csr_hit = (addr == psc_pkg::CSR_ADDR);
    endfunction : csr_hit

    function automatic logic [15:0] csr_view(input psc_top_state_t s);
        logic [15:0] v;
        v = psc_pkg::CSR_RESET;
        v[5:0] = s.modes;
        v[psc_pkg::IRQ_EN_POS] = s.irq_en;
        v[psc_pkg::FLAG_A_POS] = s.flags[0];
        v[psc_pkg::FLAG_B_POS] = s.flags[1];
        v[psc_pkg::FLAG_C_POS] = s.flags[2];
        csr_view = v & ~psc_pkg::RSVD_MASK;
    endfunction : csr_view

    assign fault_n = {fault_in_c, fault_in_b, fault_in_a};

    psc_prescaler u_prescaler (
        .clock (clock),
        .rst   (rst),
        .tick  (tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_det
            psc_detector u_det (
                .clock   (clock),
                .rst     (rst),
                .fault_n (fault_n[gi]),
                .mode    (r.modes[2*gi+1:2*gi]),
                .tick    (tick),
                .req     (det_req[gi])
            );
        end
    endgenerate

    always_comb
    begin
        n = r;
        do_write = r.aw_have && r.w_have && !r.bvalid;
        wr_hit = do_write && csr_hit(r.aw_addr);
        // write channels are taken independently, in either order
        if (s_axi_awvalid && r.awready)
        begin
            n.aw_addr = s_axi_awaddr;
            n.aw_have = 1'b1;
        end
        if (s_axi_wvalid && r.wready)
        begin
            n.w_data = s_axi_wdata[15:0];
            n.w_strb = s_axi_wstrb[1:0];
            n.w_have = 1'b1;
        end
        if (r.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        if (do_write)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_hit ? psc_pkg::RESP_OKAY : psc_pkg::RESP_SLVERR;
        end
        if (wr_hit && r.w_strb[0])
            n.modes = r.w_data[5:0];
        if (wr_hit && r.w_strb[1])
        begin
            n.irq_en = r.w_data[psc_pkg::IRQ_EN_POS];
            // a flag must be read as one again before each clear
            for (int i = 0; i < 3; i++)
            begin
                if (r.seen[i] && !r.w_data[psc_pkg::FLAG_A_POS+i])
                    n.flags[i] = 1'b0;
            end
            n.seen = 3'h0;
        end
        // read channel
        if (r.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (s_axi_arvalid && r.arready)
        begin
            n.rvalid = 1'b1;
            if (csr_hit(s_axi_araddr))
            begin
                n.rdata = {16'h0000, csr_view(r)};
                n.rresp = psc_pkg::RESP_OKAY;
                n.seen = n.seen | r.flags;
            end
            else
            begin
                n.rdata = 32'h0000_0000;
                n.rresp = psc_pkg::RESP_SLVERR;
            end
        end
        // a new request wins over a clear in the same cycle
        for (int i = 0; i < 3; i++)
        begin
            if (det_req[i])
                n.flags[i] = 1'b1;
        end
        n.awready = !n.aw_have;
        n.wready = !n.w_have;
        n.arready = !n.rvalid;
        n.irq = r.irq_en && (|r.flags);
        hiz = (|r.flags) || standby_req || osc_halt;
        for (int i = 0; i < 6; i++)
        begin
            // pins given to other functions keep their own drive
            if (hiz && pin_func_ok[i])
            begin
                n.pin_out[i] = 1'b0;
                n.pin_oe[i] = 1'b0;
            end
            else
            begin
                n.pin_out[i] = timer_out[i];
                n.pin_oe[i] = timer_oe[i];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            r <= '0;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
        end
        else
            r <= n;
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign pin_out = r.pin_out;
    assign pin_oe = r.pin_oe;
    assign fault_irq = r.irq;

    fault_forces_hiz_a: assert property (
        $rose(|r.flags) |=> (pin_oe & $past(pin_func_ok)) == 6'h00)
        else $error("pins not high impedance after fault");

    req_sets_flag_a: assert property (
        (|det_req) |=> (r.flags & $past(det_req)) == $past(det_req))
        else $error("request did not set flag");

    flag_hold_a: assert property (
        (r.flags[1] && !(wr_hit && r.w_strb[1] && r.seen[1])) |=> r.flags[1])
        else $error("flag cleared without read then write zero");

    irq_source_a: assert property (
        fault_irq |-> $past(r.irq_en) && $past(|r.flags))
        else $error("interrupt without enabled flag");

    release_pins_a: assert property (
        (r.flags == 3'h0 && !standby_req && !osc_halt) |=>
        pin_oe == $past(timer_oe) && pin_out == $past(timer_out))
        else $error("pins not released with flags clear");

    reserved_zero_a: assert property (
        s_axi_rvalid |-> (s_axi_rdata & {16'hFFFF, psc_pkg::RSVD_MASK}) == 32'h0)
        else $error("reserved bits read nonzero");

    standby_hiz_a: assert property (
        (standby_req || osc_halt) |=> (pin_oe & $past(pin_func_ok)) == 6'h00)
        else $error("pins driven in standby or oscillator halt");

    other_func_a: assert property (
        !pin_func_ok[0] |=> pin_oe[0] == $past(timer_oe[0]))
        else $error("pin in other function was forced");

    other_pins_a: assert property (
        (pin_func_ok != 6'h3F) |=>
        ((pin_oe ^ $past(timer_oe)) & ~$past(pin_func_ok)) == 6'h00)
        else $error("pin outside forcing functions did not follow timer");

    hiz_held_a: assert property (
        (|r.flags) |=> (pin_oe & $past(pin_func_ok)) == 6'h00)
        else $error("pins released while a flag is set");

    forced_low_a: assert property (
        (|r.flags) |=> (pin_out & $past(pin_func_ok)) == 6'h00)
        else $error("forced pin still shows timer data");

    flag_cause_a: assert property (
        (r.flags & ~$past(r.flags) & ~$past(det_req)) == 3'h0)
        else $error("flag set without an accepted request");

    irq_follow_a: assert property (
        (r.irq_en && (|r.flags)) |=> fault_irq)
        else $error("interrupt missing with flag set and enabled");

    irq_off_a: assert property (
        !r.irq_en |=> !fault_irq)
        else $error("interrupt raised while disabled");

    mode_store_a: assert property (
        (wr_hit && r.w_strb[0]) |=> r.modes == $past(r.w_data[5:0]))
        else $error("mode write did not land");

    irq_en_store_a: assert property (
        (wr_hit && r.w_strb[1]) |=> r.irq_en == $past(r.w_data[psc_pkg::IRQ_EN_POS]))
        else $error("interrupt enable write did not land");

    read_marks_a: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == psc_pkg::CSR_ADDR) |=>
        (r.seen & $past(r.flags)) == $past(r.flags))
        else $error("read of a set flag was not remembered");

    req_to_hiz_a: assert property (
        (|det_req) |=> ##1 (pin_oe & $past(pin_func_ok)) == 6'h00)
        else $error("request did not reach the pins in two cycles");

    standby_low_a: assert property (
        (standby_req || osc_halt) |=> (pin_out & $past(pin_func_ok)) == 6'h00)
        else $error("forced pin shows timer data in standby or halt");

    // set wins over clear, so a same-cycle request is left out
    genvar fi;
    generate
        for (fi = 0; fi < 3; fi++)
        begin : g_flag_chk
            flag_keep_a: assert property (
                @(posedge clock) disable iff (rst)
                (r.flags[fi] && !(wr_hit && r.w_strb[1] && r.seen[fi])) |=> r.flags[fi])
                else $error("flag cleared without read then write zero");
            flag_clear_a: assert property (
                @(posedge clock) disable iff (rst)
                (r.flags[fi] && r.seen[fi] && wr_hit && r.w_strb[1] && !det_req[fi]
                 && !r.w_data[psc_pkg::FLAG_A_POS+fi]) |=> !r.flags[fi])
                else $error("flag not cleared by zero after reading one");
        end
    endgenerate
endmodule : psc_top
`default_nettype wire

// ==== shared/psc_pkg.sv ====
// constants shared by the output shutdown control block
package psc_pkg;
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  CSR_ADDR      = 4'h0;
    localparam logic [15:0] CSR_RESET     = 16'h0000;
    localparam int          MODE_A_POS    = 0;
    localparam int          MODE_B_POS    = 2;
    localparam int          MODE_C_POS    = 4;
    localparam int          IRQ_EN_POS    = 8;
    localparam int          FLAG_A_POS    = 12;
    localparam int          FLAG_B_POS    = 13;
    localparam int          FLAG_C_POS    = 14;
    localparam logic [15:0] RSVD_MASK     = 16'h8EC0;
    localparam logic [1:0]  MODE_EDGE     = 2'h0;
    localparam logic [1:0]  MODE_DIV8     = 2'h1;
    localparam logic [1:0]  MODE_DIV16    = 2'h2;
    localparam logic [1:0]  MODE_DIV128   = 2'h3;
    localparam int          DIV_8         = 8;
    localparam int          DIV_16        = 16;
    localparam int          DIV_128       = 128;
    localparam int          PRESCALE_W    = 7;
    localparam logic [4:0]  SAMPLE_COUNT  = 5'h10;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : psc_pkg

// ==== rtl/psc_prescaler.sv ====
// sampling tick generator: one-cycle ticks at clock/8, /16 and /128
`timescale 1ns/100ps
`default_nettype none
module psc_prescaler (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // ticks, bit 0 = /8, bit 1 = /16, bit 2 = /128
    output logic [2:0]      tick
);
    typedef struct packed {
        logic [psc_pkg::PRESCALE_W-1:0] cnt;
        logic [2:0]                     tick;
    } psc_pre_state_t;

    psc_pre_state_t r;
    psc_pre_state_t n;

    always_comb
    begin
        n = r;
        n.cnt = r.cnt + 7'h01;
        // all three share one counter so the ticks stay aligned
        n.tick[0] = (r.cnt[2:0] == 3'(psc_pkg::DIV_8 - 1));
        n.tick[1] = (r.cnt[3:0] == 4'(psc_pkg::DIV_16 - 1));
        n.tick[2] = (r.cnt == 7'(psc_pkg::DIV_128 - 1));
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            r <= '0;
        else
            r <= n;
    end

    assign tick = r.tick;

    tick_align_a: assert property (@(posedge clock) disable iff (rst)
        r.tick[2] |-> r.tick[1] && r.tick[0])
        else $error("slow tick not aligned with faster ticks");
endmodule : psc_prescaler
`default_nettype wire

// ==== rtl/psc_detector.sv ====
// one fault input: synchroniser, falling edge and 16-sample low detection
`timescale 1ns/100ps
`default_nettype none
module psc_detector (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // fault pin, active low, asynchronous
    input  wire logic       fault_n,
    // mode and sampling ticks
    input  wire logic [1:0] mode,
    input  wire logic [2:0] tick,
    // accepted request, one-cycle pulse
    output logic            req
);
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       prev;
        logic [4:0] cnt;
        logic [1:0] mode;
        logic       req;
    } psc_det_state_t;

    psc_det_state_t r;
    psc_det_state_t n;
    logic           smp;

    always_comb
    begin
        n = r;
        smp = 1'b0;
        n.s1 = fault_n;
        n.s2 = r.s1;
        n.prev = r.s2;
        n.mode = mode;
        n.req = 1'b0;
        case (mode)
            psc_pkg::MODE_DIV8:   smp = tick[0];
            psc_pkg::MODE_DIV16:  smp = tick[1];
            psc_pkg::MODE_DIV128: smp = tick[2];
            default:              smp = 1'b0;
        endcase
        if (mode == psc_pkg::MODE_EDGE)
        begin
            n.cnt = '0;
            n.req = r.prev && !r.s2;
        end
        else if (mode != r.mode)
            n.cnt = '0;
        else if (smp)
        begin
            if (r.s2)
                n.cnt = '0;
            else if (r.cnt == psc_pkg::SAMPLE_COUNT - 5'h01)
            begin
                n.cnt = '0;
                n.req = 1'b1;
            end
            else
                n.cnt = r.cnt + 5'h01;
        end
    end

    // pins idle high, so the edge history resets high
    always_ff @(posedge clock)
    begin
        if (rst)
            r <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, cnt: 5'h00, mode: 2'h0, req: 1'b0};
        else
            r <= n;
    end

    assign req = r.req;

    edge_accept_a: assert property (@(posedge clock) disable iff (rst)
        (mode == psc_pkg::MODE_EDGE && $past(mode) == psc_pkg::MODE_EDGE
         && r.prev && !r.s2) |=> req)
        else $error("falling edge not accepted");
    level_count_a: assert property (@(posedge clock) disable iff (rst)
        (req && r.mode != psc_pkg::MODE_EDGE) |-> $past(r.cnt) == 5'h0F && !$past(r.s2))
        else $error("level request without sixteen low samples");
endmodule : psc_detector
`default_nettype wire

// ==== verification/psc_partner.sv ====
// fault sources and pwm timer drive facing the shutdown block
`timescale 1ns/100ps
`default_nettype none
module psc_partner (
    // fault requests from the bench, 1 = pull the pin low
    input  wire logic [2:0] fault_low,
    // fault pins, active low
    output logic            fault_in_a,
    output logic            fault_in_b,
    output logic            fault_in_c,
    // pwm timer drive
    output logic [5:0]      timer_out,
    output logic [5:0]      timer_oe
);
    // pins rest high, so a level mode is never chosen on a low line
    assign fault_in_a = ~fault_low[0];
    assign fault_in_b = ~fault_low[1];
    assign fault_in_c = ~fault_low[2];
    // mixed pattern so a stuck output bit shows
    assign timer_out  = 6'h2B;
    assign timer_oe   = 6'h3F;
endmodule : psc_partner
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the output shutdown control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clock, rst;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [3:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        fault_in_a, fault_in_b, fault_in_c, standby_req, osc_halt, fault_irq;
    logic [5:0]  timer_out, timer_oe, pin_func_ok, pin_out, pin_oe;
    logic [2:0]  fault_low;
    int          err_total, n_compared, dv;

    psc_top dut (
        .clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'h3), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .fault_in_a, .fault_in_b, .fault_in_c, .standby_req, .osc_halt,
        .timer_out, .timer_oe, .pin_func_ok, .pin_out, .pin_oe, .fault_irq
    );

    psc_partner far_side (
        .fault_low, .fault_in_a, .fault_in_b, .fault_in_c, .timer_out, .timer_oe
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // values read at the edge are pre-update, the design registers with nonblocking
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rd

    task automatic wait_oe(input logic [5:0] e, input int lim);
        int n;
        n = 0;
        while (pin_oe !== e && n < lim)
        begin
            @(posedge clock);
            n++;
        end
        chk("pin_oe", {26'h0, e}, {26'h0, pin_oe});
    endtask : wait_oe

    initial
    begin
        rst = 1'b1;
        // bready and rready stay high: every answer is taken at once
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h0;
        {standby_req, osc_halt} = 2'h0;
        fault_low = 3'h0;
        pin_func_ok = 6'h3F;
        err_total = 0;
        n_compared = 0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        rd(psc_pkg::CSR_ADDR, 32'h0, psc_pkg::RESP_OKAY);
        chk("pin_out", 32'h2B, {26'h0, pin_out});
        wait_oe(6'h3F, 2);
        // ones to flags are ignored; reserved bits only ever get zero
        wr(psc_pkg::CSR_ADDR, 32'h713F, psc_pkg::RESP_OKAY);
        rd(psc_pkg::CSR_ADDR, 32'h013F, psc_pkg::RESP_OKAY);
        wr(4'h4, 32'h0100, psc_pkg::RESP_SLVERR);
        rd(4'h4, 32'h0, psc_pkg::RESP_SLVERR);
        // edge mode on input a, pin 0 outside the forcing functions
        pin_func_ok <= 6'h3E;
        wr(psc_pkg::CSR_ADDR, 32'h0100, psc_pkg::RESP_OKAY);
        fault_low <= 3'h1;
        wait_oe(6'h01, 20);
        chk("pin_out", 32'h1, {26'h0, pin_out});
        chk("fault_irq", 32'h1, {31'h0, fault_irq});
        fault_low <= 3'h0;
        rd(psc_pkg::CSR_ADDR, 32'h1100, psc_pkg::RESP_OKAY);
        // ones leave flags alone and use up the read
        wr(psc_pkg::CSR_ADDR, 32'h7100, psc_pkg::RESP_OKAY);
        wr(psc_pkg::CSR_ADDR, 32'h6000, psc_pkg::RESP_OKAY);
        repeat (2) @(posedge clock);
        chk("fault_irq", 32'h0, {31'h0, fault_irq});
        rd(psc_pkg::CSR_ADDR, 32'h1000, psc_pkg::RESP_OKAY);
        wait_oe(6'h01, 1);
        wr(psc_pkg::CSR_ADDR, 32'h6100, psc_pkg::RESP_OKAY);
        rd(psc_pkg::CSR_ADDR, 32'h0100, psc_pkg::RESP_OKAY);
        wait_oe(6'h3F, 4);
        chk("fault_irq", 32'h0, {31'h0, fault_irq});
        pin_func_ok <= 6'h3F;
        // level modes: a at /8, b at /16, c at /128, with two high samples
        for (int k = 0; k < 3; k++)
        begin
            dv = (k == 0) ? psc_pkg::DIV_8 : (k == 1) ? psc_pkg::DIV_16 : psc_pkg::DIV_128;
            wr(psc_pkg::CSR_ADDR, (k + 1) << (2 * k), psc_pkg::RESP_OKAY);
            fault_low <= 3'(1 << k);
            repeat (10 * dv) @(posedge clock);
            fault_low <= 3'h0;
            repeat (2 * dv) @(posedge clock);
            fault_low <= 3'(1 << k);
            repeat (14 * dv) @(posedge clock);
            chk("pin_oe early", 32'h3F, {26'h0, pin_oe});
            wait_oe(6'h00, 3 * dv + 10);
            fault_low <= 3'h0;
            rd(psc_pkg::CSR_ADDR, ((k + 1) << (2 * k)) | (1 << (12 + k)),
               psc_pkg::RESP_OKAY);
            wr(psc_pkg::CSR_ADDR, 32'h7000 & ~(1 << (12 + k)), psc_pkg::RESP_OKAY);
            wait_oe(6'h3F, 4);
        end
        // standby and oscillator halt force the pins too
        for (int j = 0; j < 2; j++)
        begin
            standby_req <= (j == 0);
            osc_halt <= (j == 1);
            wait_oe(6'h00, 4);
            {standby_req, osc_halt} <= 2'h0;
            wait_oe(6'h3F, 4);
        end
        // reset alone releases forced pins and clears the flags
        fault_low <= 3'h2;
        wait_oe(6'h00, 20);
        rst <= 1'b1;
        fault_low <= 3'h0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        wait_oe(6'h3F, 4);
        rd(psc_pkg::CSR_ADDR, 32'h0, psc_pkg::RESP_OKAY);
        results();
    end

    // run needs about 4400 cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        results();
    end
endmodule : tb
`default_nettype wire
